// ===== verilog/acr_cfg.svh
// offsets, field positions, reset values and fixed codes of the calibration register slice
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

`define ACR_ADDR_W        7
`define ACR_DATA_W        24
`define ACR_PTR_W         4
`define ACR_MAX_CH        16

`define ACR_OFF_CH_PTR    7'h25
`define ACR_OFF_SOC       7'h26
`define ACR_OFF_GAIN      7'h27
`define ACR_OFF_CODE      7'h40

`define ACR_PTR_MSB       3
`define ACR_PTR_LSB       0
`define ACR_CODE_MSB      23
`define ACR_CODE_LSB      6
`define ACR_CODE_W        18

`define ACR_PTR_RST       4'h0
`define ACR_SOC_RST       24'h000000
`define ACR_GAIN_RST      24'hC00000
`define ACR_CODE_RST      18'h00000
`define ACR_GAIN_UNITY    24'h800000
`define ACR_SOC_ZERO      24'h000000
`define ACR_RD_ZERO       24'h000000

`endif

// ===== verilog/acr_pkg.sv
// types shared by the calibration register slice
package acr_pkg;

  // state of the register front end
  typedef struct packed
  {
    logic [3:0]  ptr;
    logic [17:0] code;
    logic [23:0] rdata;
    logic        rvalid;
    logic [23:0] corr_off;
    logic [23:0] corr_gain;
  } acr_main_state_t;

endpackage

// ===== verilog/acr_coeff_store.sv
// per-channel offset and gain coefficient storage
`timescale 1ns/10ps
`include "acr_cfg.svh"

module acr_coeff_store #(
  parameter int NUM_CH = `ACR_MAX_CH
) (
  input  wire logic        clk_i,       // system clock
  input  wire logic        sys_rst_i,   // synchronous reset, active high
  input  wire logic        wr_off_i,    // write offset of wr_idx_i
  input  wire logic        wr_gain_i,   // write gain of wr_idx_i
  input  wire logic [3:0]  wr_idx_i,    // channel written and read back
  input  wire logic [23:0] wdata_i,     // coefficient to store
  input  wire logic [3:0]  corr_idx_i,  // channel whose coefficients feed correction
  output logic      [23:0] rd_off_o,    // offset of wr_idx_i
  output logic      [23:0] rd_gain_o,   // gain of wr_idx_i
  output logic      [23:0] cr_off_o,    // offset of corr_idx_i
  output logic      [23:0] cr_gain_o    // gain of corr_idx_i
);

  typedef struct packed
  {
    logic [NUM_CH-1:0][23:0] off;
    logic [NUM_CH-1:0][23:0] gain;
  } acr_store_state_t;

  acr_store_state_t state_reg;
  acr_store_state_t state_next;

  // the index ports are four bits wide, so no more than 16 channels can be reached
  if (NUM_CH < 1 || NUM_CH > `ACR_MAX_CH)
  begin
    $error("acr_coeff_store: NUM_CH must be 1 to 16");
  end

  logic wr_in_range;
  logic corr_in_range;
  assign wr_in_range   = 32'(wr_idx_i) < NUM_CH;
  assign corr_in_range = 32'(corr_idx_i) < NUM_CH;

  // ******************************************
  // storage update
  // ******************************************
  // every channel owns its own pair; outside reset only the pointed entry may change
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (wr_off_i && wr_idx_i == 4'(i))
        state_next.off[i] = wdata_i;
      if (wr_gain_i && wr_idx_i == 4'(i))
        state_next.gain[i] = wdata_i;
    end
    if (sys_rst_i)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        state_next.off[i]  = `ACR_SOC_RST;
        state_next.gain[i] = `ACR_GAIN_RST;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    state_reg <= state_next;
  end

  // pointers past the last channel read as zero and store nothing
  assign rd_off_o  = wr_in_range   ? state_reg.off[wr_idx_i]    : `ACR_RD_ZERO;
  assign rd_gain_o = wr_in_range   ? state_reg.gain[wr_idx_i]   : `ACR_RD_ZERO;
  assign cr_off_o  = corr_in_range ? state_reg.off[corr_idx_i]  : `ACR_RD_ZERO;
  assign cr_gain_o = corr_in_range ? state_reg.gain[corr_idx_i] : `ACR_RD_ZERO;

  // ******************************************
  // checks
  // ******************************************
  a_gain_reset_val: assert property (@(posedge clk_i)
    sys_rst_i |=> state_reg.gain[0] == `ACR_GAIN_RST && state_reg.off[0] == `ACR_SOC_RST)
    else $error("coefficients not at reset value after reset");

  // reset is released by the edge that starts an attempt, so the antecedent excludes it
  a_other_ch_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_off_i && wr_idx_i != corr_idx_i) ##1 (corr_idx_i == $past(corr_idx_i))
      |-> cr_off_o == $past(cr_off_o))
    else $error("write to one channel changed another channel");

endmodule

// ===== verilog/acr_cal_regs.sv
// calibration pointer, coefficient access and output code write registers
`timescale 1ns/10ps
`include "acr_cfg.svh"

// Operation
// - four-bit read/write channel pointer in bits 3:0, resets to zero, upper bits zero
// - pointer uses the same channel numbering as the active input select
// - offset and gain registers reach only the channel named by the pointer
// - offset coefficient is 24-bit two's complement, read/write, resets to zero
// - gain coefficient is 24-bit unsigned, read/write, resets to 0xC00000
// - coefficient writes dropped while converting on the pointed channel
// - output code is 18 bits in 23:6, bits 5:0 reserved
// - output code is write-only, resets to zero, reads return zero
// - gain bypass makes correction use 0x800000 for every channel
// - offset bypass makes correction use zero for every channel
module acr_cal_regs #(
  parameter int NUM_CH = `ACR_MAX_CH
) (
  input  wire logic        clk_i,          // system clock, 250 MHz
  input  wire logic        sys_rst_i,      // synchronous reset, active high
  input  wire logic        wr_en_i,        // one-cycle register write strobe
  input  wire logic        rd_en_i,        // one-cycle register read strobe
  input  wire logic [6:0]  addr_i,         // register address
  input  wire logic [23:0] wdata_i,        // write data
  input  wire logic        conv_busy_i,    // an ADC conversion is running
  input  wire logic [3:0]  active_input_channel_select_i, // channel being converted
  input  wire logic        gain_correction_bypass_i,      // global gain bypass
  input  wire logic        offset_correction_bypass_i,    // global offset bypass
  input  wire logic [3:0]  corr_ch_i,      // channel the correction datapath asks for
  output logic      [23:0] rdata_o,        // read data, held until next read
  output logic             rvalid_o,       // one-cycle pulse with rdata_o
  output logic      [3:0]  cal_channel_pointer_o, // current pointer
  output logic      [17:0] output_code_o,  // analog output code
  output logic      [23:0] corr_offset_o,  // offset applied to corr_ch_i
  output logic      [23:0] corr_gain_o     // gain applied to corr_ch_i
);

  acr_pkg::acr_main_state_t state_reg;
  acr_pkg::acr_main_state_t state_next;

  // the pointer is four bits wide, so no more than 16 channels can be named
  if (NUM_CH < 1 || NUM_CH > `ACR_MAX_CH)
  begin
    $error("acr_cal_regs: NUM_CH must be 1 to 16");
  end

  logic        hit_ptr;
  logic        hit_soc;
  logic        hit_gain;
  logic        hit_code;
  logic        wr_blocked;
  logic        wr_off;
  logic        wr_gain;
  logic [23:0] st_off;
  logic [23:0] st_gain;
  logic [23:0] st_cr_off;
  logic [23:0] st_cr_gain;

  // ******************************************
  // address decode
  // ******************************************
  assign hit_ptr  = addr_i == `ACR_OFF_CH_PTR;
  assign hit_soc  = addr_i == `ACR_OFF_SOC;
  assign hit_gain = addr_i == `ACR_OFF_GAIN;
  assign hit_code = addr_i == `ACR_OFF_CODE;

  // pointer and active select share one numbering, so a plain compare finds the clash
  assign wr_blocked = conv_busy_i && (state_reg.ptr == active_input_channel_select_i);
  assign wr_off     = wr_en_i && hit_soc && !wr_blocked;
  assign wr_gain    = wr_en_i && hit_gain && !wr_blocked;

  acr_coeff_store #(
    .NUM_CH (NUM_CH)
  ) i_acr_coeff_store (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_off_i   (wr_off),
    .wr_gain_i  (wr_gain),
    .wr_idx_i   (state_reg.ptr),
    .wdata_i    (wdata_i),
    .corr_idx_i (corr_ch_i),
    .rd_off_o   (st_off),
    .rd_gain_o  (st_gain),
    .cr_off_o   (st_cr_off),
    .cr_gain_o  (st_cr_gain)
  );

  // ******************************************
  // register state
  // ******************************************
  always_comb
  begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    if (wr_en_i && hit_ptr)
      state_next.ptr = wdata_i[`ACR_PTR_MSB:`ACR_PTR_LSB];
    if (wr_en_i && hit_code)
      state_next.code = wdata_i[`ACR_CODE_MSB:`ACR_CODE_LSB];
    if (rd_en_i)
    begin
      state_next.rvalid = 1'b1;
      // write-only code and unmapped addresses read as zero
      state_next.rdata  = `ACR_RD_ZERO;
      if (hit_ptr)
        state_next.rdata = {20'h00000, state_reg.ptr};
      else if (hit_soc)
        state_next.rdata = st_off;
      else if (hit_gain)
        state_next.rdata = st_gain;
    end
    // correction values are one cycle behind corr_ch_i; the datapath is slow enough
    state_next.corr_off  = offset_correction_bypass_i ? `ACR_SOC_ZERO : st_cr_off;
    state_next.corr_gain = gain_correction_bypass_i ? `ACR_GAIN_UNITY : st_cr_gain;
    if (sys_rst_i)
    begin
      state_next.ptr       = `ACR_PTR_RST;
      state_next.code      = `ACR_CODE_RST;
      state_next.rdata     = `ACR_RD_ZERO;
      state_next.rvalid    = 1'b0;
      state_next.corr_off  = `ACR_SOC_RST;
      state_next.corr_gain = `ACR_GAIN_RST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state_reg <= state_next;
  end

  assign rdata_o               = state_reg.rdata;
  assign rvalid_o              = state_reg.rvalid;
  assign cal_channel_pointer_o = state_reg.ptr;
  assign output_code_o         = state_reg.code;
  assign corr_offset_o         = state_reg.corr_off;
  assign corr_gain_o           = state_reg.corr_gain;

  // ******************************************
  // checks
  // ******************************************
  // reset may drop at the very edge that starts an attempt, so every antecedent except
  // that of a_ptr_reset_zero excludes a reset cycle; the host leaves one idle cycle between accesses
  a_ptr_write_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_en_i && hit_ptr) ##1 !wr_en_i ##1 (rd_en_i && hit_ptr && !wr_en_i)
      |=> rdata_o == {20'h00000, $past(wdata_i[3:0], 3)})
    else $error("pointer readback differs from value written");

  a_ptr_reset_zero: assert property (@(posedge clk_i)
    sys_rst_i |=> cal_channel_pointer_o == `ACR_PTR_RST)
    else $error("pointer not zero after reset");

  a_ptr_upper_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && rd_en_i && hit_ptr) |=> rdata_o[23:4] == 20'h00000)
    else $error("pointer read returned reserved bits");

  a_ptr_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !(wr_en_i && hit_ptr))
      |=> cal_channel_pointer_o == $past(cal_channel_pointer_o))
    else $error("pointer changed without a pointer write");

  a_soc_roundtrip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_en_i && hit_soc && !wr_blocked && 32'(state_reg.ptr) < NUM_CH)
      ##1 !wr_en_i ##1 (rd_en_i && hit_soc && !wr_en_i) |=> rdata_o == $past(wdata_i, 3))
    else $error("offset readback differs from value written");

  a_gain_roundtrip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_en_i && hit_gain && !wr_blocked && 32'(state_reg.ptr) < NUM_CH)
      ##1 !wr_en_i ##1 (rd_en_i && hit_gain && !wr_en_i) |=> rdata_o == $past(wdata_i, 3))
    else $error("gain readback differs from value written");

  a_offset_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_en_i && hit_soc && 32'(state_reg.ptr) < NUM_CH
      && !(conv_busy_i && state_reg.ptr == active_input_channel_select_i))
      |=> st_off == $past(wdata_i))
    else $error("offset write outside a clash did not land");

  a_gain_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_en_i && hit_gain && 32'(state_reg.ptr) < NUM_CH
      && !(conv_busy_i && state_reg.ptr == active_input_channel_select_i))
      |=> st_gain == $past(wdata_i))
    else $error("gain write outside a clash did not land");

  a_busy_write_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_en_i && (hit_soc || hit_gain) && conv_busy_i
      && state_reg.ptr == active_input_channel_select_i)
      |=> st_off == $past(st_off) && st_gain == $past(st_gain))
    else $error("coefficient changed by write during conversion");

  a_code_capture: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && wr_en_i && hit_code) |=> output_code_o == $past(wdata_i[23:6]))
    else $error("output code not taken from bits 23:6");

  a_code_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !(wr_en_i && hit_code)) |=> output_code_o == $past(output_code_o))
    else $error("output code changed without a code write");

  a_code_hidden: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && rd_en_i && hit_code) |=> rvalid_o && rdata_o == `ACR_RD_ZERO)
    else $error("output code location returned data");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && rd_en_i && !hit_ptr && !hit_soc && !hit_gain) |=> rdata_o == `ACR_RD_ZERO)
    else $error("unreadable location returned data");

  a_rvalid_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && rd_en_i) |=> rvalid_o)
    else $error("read not answered in the next cycle");

  a_rvalid_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !rd_en_i) |=> !rvalid_o)
    else $error("read answer without a read");

  a_rdata_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !rd_en_i) |=> rdata_o == $past(rdata_o))
    else $error("read data changed without a read");

  a_gain_bypass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && gain_correction_bypass_i) |=> corr_gain_o == `ACR_GAIN_UNITY)
    else $error("gain bypass did not force unity gain");

  a_offset_bypass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && offset_correction_bypass_i) |=> corr_offset_o == `ACR_SOC_ZERO)
    else $error("offset bypass did not force zero offset");

  a_corr_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !gain_correction_bypass_i) |=> corr_gain_o == $past(st_cr_gain))
    else $error("correction gain does not follow stored coefficient");

  a_offset_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!sys_rst_i && !offset_correction_bypass_i) |=> corr_offset_o == $past(st_cr_off))
    else $error("correction offset does not follow stored coefficient");

endmodule

// ===== dv/acr_host_model.sv
// host model driving the register strobe port of the calibration slice
`timescale 1ns/10ps

module acr_host_model (
  input  wire logic        clk_i,    // system clock
  input  wire logic [23:0] rdata_i,  // read data
  input  wire logic        rvalid_i, // read answer pulse
  output logic             wr_en_o,  // write strobe
  output logic             rd_en_o,  // read strobe
  output logic      [6:0]  addr_o,   // register address
  output logic      [23:0] wdata_o   // write data
);
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 7'h00;
    wdata_o = 24'h000000;
  end

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    // idle lines show the inverse so a stale value is never mistaken for data
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [23:0] d, output int lat);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o  <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o  <= ~a;
    d   = 24'h000000;
    lat = 0;
    while (lat < 4)
    begin
      @(posedge clk_i);
      lat++;
      if (rvalid_i === 1'b1)
      begin
        d = rdata_i;
        break;
      end
    end
  endtask
endmodule

// ===== dv/acr_cal_regs_tb.sv
// self-checking bench for the calibration register slice
`timescale 1ns/10ps
`include "acr_cfg.svh"

module acr_cal_regs_tb;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        busy      = 1'b0;
  logic [3:0]  act_ch    = 4'h0;
  logic        gbyp      = 1'b0;
  logic        obyp      = 1'b0;
  logic [3:0]  corr_ch   = 4'h0;
  logic        wr_en;
  logic        rd_en;
  logic [6:0]  addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic        rvalid;
  logic [3:0]  ptr;
  logic [17:0] code;
  logic [23:0] c_off;
  logic [23:0] c_gain;
  int          err_total   = 0;
  int          comparisons = 0;

  always #2 clk_i = ~clk_i;

  acr_host_model i_acr_host_model (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

  acr_cal_regs #(.NUM_CH(16)) i_acr_cal_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .conv_busy_i(busy),
    .active_input_channel_select_i(act_ch), .gain_correction_bypass_i(gbyp),
    .offset_correction_bypass_i(obyp), .corr_ch_i(corr_ch), .rdata_o(rdata),
    .rvalid_o(rvalid), .cal_channel_pointer_o(ptr), .output_code_o(code),
    .corr_offset_o(c_off), .corr_gain_o(c_gain));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [23:0] off_of(input logic [3:0] ch);
    return {20'h80000, ch};
  endfunction

  function automatic logic [23:0] gain_of(input logic [3:0] ch);
    return {20'h3FFF0, ch};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic w(input logic [6:0] a, input logic [23:0] d);
    i_acr_host_model.wr(a, d);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [23:0] exp, input string nm);
    logic [23:0] d;
    int          lat;
    i_acr_host_model.rd(a, d, lat);
    chk({nm, " latency"}, 24'(lat), 24'h000001);
    if (lat >= 4)
      end_sim();
    else
      chk(nm, d, exp);
  endtask

  // inputs change at an edge; correction outputs lag one edge, so settle two
  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rdc(`ACR_OFF_CH_PTR, 24'h000000, "pointer");
    rdc(`ACR_OFF_SOC, 24'h000000, "offset");
    rdc(`ACR_OFF_GAIN, 24'hC00000, "gain");
    rdc(`ACR_OFF_CODE, 24'h000000, "code read");
    chk("code out", {6'h00, code}, 24'h000000);
    rdc(7'h30, 24'h000000, "unmapped");
    w(`ACR_OFF_CH_PTR, 24'hFFFFF5);
    rdc(`ACR_OFF_CH_PTR, 24'h000005, "pointer");
    chk("pointer out", {20'h00000, ptr}, 24'h000005);
    $display("test reset and pointer done");
  endtask

  task automatic t_chan();
    for (int ch = 0; ch < 16; ch++)
    begin
      w(`ACR_OFF_CH_PTR, 24'(ch));
      w(`ACR_OFF_SOC, off_of(4'(ch)));
      w(`ACR_OFF_GAIN, gain_of(4'(ch)));
    end
    for (int ch = 15; ch >= 0; ch--)
    begin
      w(`ACR_OFF_CH_PTR, 24'(ch));
      rdc(`ACR_OFF_SOC, off_of(4'(ch)), "chan offset");
      rdc(`ACR_OFF_GAIN, gain_of(4'(ch)), "chan gain");
    end
    $display("test channels done");
  endtask

  task automatic t_block();
    @(posedge clk_i);
    busy   <= 1'b1;
    act_ch <= 4'h3;
    w(`ACR_OFF_CH_PTR, 24'h000003);
    w(`ACR_OFF_SOC, 24'h123456);
    w(`ACR_OFF_GAIN, 24'h654321);
    rdc(`ACR_OFF_SOC, off_of(4'h3), "blocked offset");
    rdc(`ACR_OFF_GAIN, gain_of(4'h3), "blocked gain");
    w(`ACR_OFF_CH_PTR, 24'h000004);
    w(`ACR_OFF_SOC, 24'h123456);
    rdc(`ACR_OFF_SOC, 24'h123456, "other chan offset");
    @(posedge clk_i);
    busy <= 1'b0;
    w(`ACR_OFF_CH_PTR, 24'h000003);
    w(`ACR_OFF_GAIN, 24'h654321);
    rdc(`ACR_OFF_GAIN, 24'h654321, "idle gain");
    $display("test blocking done");
  endtask

  task automatic t_code();
    w(`ACR_OFF_CODE, 24'hABCDEF);
    @(negedge clk_i);
    chk("code out", {6'h00, code}, 24'h02AF37);
    rdc(`ACR_OFF_CODE, 24'h000000, "code read");
    w(`ACR_OFF_CODE, 24'h800000);
    @(negedge clk_i);
    chk("code out", {6'h00, code}, 24'h020000);
    $display("test output code done");
  endtask

  task automatic t_corr();
    @(posedge clk_i);
    corr_ch <= 4'h3;
    settle();
    chk("corr gain", c_gain, 24'h654321);
    chk("corr off", c_off, off_of(4'h3));
    @(posedge clk_i);
    gbyp <= 1'b1;
    settle();
    chk("corr gain", c_gain, 24'h800000);
    chk("corr off", c_off, off_of(4'h3));
    @(posedge clk_i);
    gbyp    <= 1'b0;
    obyp    <= 1'b1;
    corr_ch <= 4'h4;
    settle();
    chk("corr off", c_off, 24'h000000);
    chk("corr gain", c_gain, gain_of(4'h4));
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdc(`ACR_OFF_CH_PTR, 24'h000000, "pointer");
    rdc(`ACR_OFF_GAIN, 24'hC00000, "gain");
    $display("test correction and reset done");
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_chan();
    t_block();
    t_code();
    t_corr();
    end_sim();
  end
endmodule
